// file: include/two_wire_params.svh
// two_wire_params.svh: timing counts, select codes and field positions for the two-wire store link
// assumes core_clk runs at 50 MHz and the bus wires have pull-ups worked out by the interface
// Behaviour
// - data changes only while clock is low
// - falling data with clock high starts
// - rising data with clock high stops, standby
// - sender releases after eight; receiver acks ninth
// - ack select code matching type and pins
// - in write, ack every received byte; data bytes only with control pin low
// - read: eight bits, release, sample ack
// - master no-ack: stop sending, await stop
// - select byte: msb first, type, pins, direction
// - type 1010 memory, 0110 protection register
// - current read returns byte at counter
// - random read: address, restart, read select
// - sequential read continues while master acks
// - writes only with control pin low, page sixteen
// - silent during program cycle after write stop
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH
`define CLK_NS          20
`define WRC_MS          10
`define WRC_CYC         ((`WRC_MS * 1000000) / `CLK_NS)
`define SCL_PERIOD_NS   2500
`define SCL_QUARTER_CYC ((`SCL_PERIOD_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define TYPE_MEM        4'ha
`define TYPE_PROT       4'h6
`define SEL_TYPE_MSB    7
`define SEL_TYPE_LSB    4
`define SEL_CE_MSB      3
`define SEL_CE_LSB      1
`define SEL_RW_BIT      0
`define BYTE_BITS       4'h8
`define PROT_RESET      8'h00
`endif

// file: include/two_wire_pkg.sv
// two_wire_pkg: state and command types shared by both ends of the link
// assumes the params header is included by each user
package two_wire_pkg;
  typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3} op_e;
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_SEL   = 6'h02,
    S_ADDR  = 6'h04,
    S_WDATA = 6'h08,
    S_RDATA = 6'h10,
    S_WAIT  = 6'h20
  } dev_state_e;
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_START = 4'h2, H_STOP = 4'h4, H_BYTE = 4'h8} host_state_e;
endpackage

// file: include/two_wire_if.sv
// two_wire_if: open-drain clock and data wires between bus master and store slave
// an enable high pulls its wire low; released wires read high through the pull-up
`timescale 1ns/1ps
interface two_wire_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport master (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport slave  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// file: design/eeprom_master.sv
// eeprom_master: bus master issuing start, stop and byte transfers one command at a time
// assumes the slave end sits on the same two_wire_if; clock is made here by a quarter-period divider
`timescale 1ns/1ps
`include "two_wire_params.svh"
module eeprom_master (
  input  wire logic               core_clk,
  input  wire logic               rst,
  two_wire_if.master              bus,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire two_wire_pkg::op_e  cmd_op,
  input  wire logic [7:0]         cmd_data,
  input  wire logic               cmd_ack,
  output logic                    rsp_valid,
  output logic [7:0]              rsp_data,
  output logic                    rsp_nack
);
  import two_wire_pkg::*;
  localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYC);

  host_state_e state_ff, nxt_state;
  logic [7:0]  div_ff, nxt_div;
  logic [1:0]  q_ff, nxt_q;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [8:0]  shift_ff, nxt_shift;
  logic [8:0]  rx_ff, nxt_rx;
  logic        scl_oe_ff, nxt_scl_oe;
  logic        sda_oe_ff, nxt_sda_oe;
  logic        rsp_valid_ff, nxt_rsp_valid;
  logic        sda_m_ff, sda_s_ff;
  logic        tick;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end
    else
    begin
      sda_m_ff <= bus.sda;
      sda_s_ff <= sda_m_ff;
    end

  assign tick = (div_ff == QUARTER - 8'h01);
  assign cmd_ready = (state_ff == H_IDLE);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_q = q_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_rx = rx_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rsp_valid = 1'b0;
    case (state_ff)
      H_IDLE:
        if (cmd_valid)
        begin
          nxt_q = 2'h0;
          nxt_cnt = 4'h0;
          case (cmd_op)
            OP_START: nxt_state = H_START;
            OP_STOP:  nxt_state = H_STOP;
            OP_WRITE:
            begin
              nxt_state = H_BYTE;
              nxt_shift = {cmd_data, 1'b1};
            end
            default:
            begin
              nxt_state = H_BYTE;
              nxt_shift = {8'hff, ~cmd_ack};
            end
          endcase
        end
      H_START:
        if (tick)
        begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0:
            begin
              nxt_sda_oe = 1'b0;
              nxt_scl_oe = 1'b1;
            end
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b1;
            default:
            begin
              nxt_scl_oe = 1'b1;
              nxt_state = H_IDLE;
            end
          endcase
        end
      H_STOP:
        if (tick)
        begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0:
            begin
              nxt_sda_oe = 1'b1;
              nxt_scl_oe = 1'b1;
            end
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b0;
            default: nxt_state = H_IDLE;
          endcase
        end
      H_BYTE:
        if (tick)
        begin
          nxt_q = q_ff + 2'h1;
          case (q_ff)
            2'h0: nxt_sda_oe = ~shift_ff[8];
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_rx = {rx_ff[7:0], sda_s_ff};
            default:
            begin
              nxt_scl_oe = 1'b1;
              nxt_shift = {shift_ff[7:0], 1'b1};
              nxt_cnt = cnt_ff + 4'h1;
              if (cnt_ff == `BYTE_BITS)
              begin
                nxt_state = H_IDLE;
                nxt_rsp_valid = 1'b1;
              end
            end
          endcase
        end
      default: nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      state_ff <= H_IDLE;
      div_ff <= 8'h00;
      q_ff <= 2'h0;
      cnt_ff <= 4'h0;
      shift_ff <= 9'h1ff;
      rx_ff <= 9'h000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      q_ff <= nxt_q;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      rx_ff <= nxt_rx;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      rsp_valid_ff <= nxt_rsp_valid;
    end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_ff;
  assign bus.host_sda_oe = sda_oe_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rx_ff[8:1];
  assign rsp_nack = rx_ff[0];
endmodule // eeprom_master

// file: design/eeprom_slave.sv
// eeprom_slave: two-wire store slave with 256-byte array and one protection byte
// assumes scl and sda come asynchronously from the bus; straps and the control pin are slow levels
`timescale 1ns/1ps
`include "two_wire_params.svh"
module eeprom_slave #(
  parameter int PROG_CYCLES = `WRC_CYC
) (
  input  wire logic  core_clk,
  input  wire logic  rst,
  two_wire_if.slave  bus,
  input  wire logic  chip_enable_pin_0,
  input  wire logic  chip_enable_pin_1,
  input  wire logic  chip_enable_pin_2,
  input  wire logic  write_control_pin,
  output logic       prog_busy
);
  import two_wire_pkg::*;

  dev_state_e  state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic        in_ack_ff, nxt_in_ack;
  logic        m_ack_ff, nxt_m_ack;
  logic [7:0]  shift_ff, nxt_shift;
  logic        drive_ff, nxt_drive;
  logic [7:0]  addr_ff, nxt_addr;
  logic        prot_sel_ff, nxt_prot_sel;
  logic [7:0]  prot_ff, nxt_prot;
  logic        wrote_ff, nxt_wrote;
  logic [18:0] prog_ff, nxt_prog;
  logic        mem_we;
  logic [7:0]  mem [0:255];
  logic [7:0]  rd_byte;
  logic [5:0]  pin_m_ff, pin_s_ff;
  logic        scl_d_ff, sda_d_ff;
  logic        scl_rise, scl_fall, start_seen, stop_seen, busy, sel_match, wc_high;

  // bit 5 scl, 4 sda, 3 write control, 2..0 chip enables
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pin_m_ff <= 6'h30;
      pin_s_ff <= 6'h30;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      pin_m_ff <= {bus.scl, bus.sda, write_control_pin, chip_enable_pin_2, chip_enable_pin_1, chip_enable_pin_0};
      pin_s_ff <= pin_m_ff;
      scl_d_ff <= pin_s_ff[5];
      sda_d_ff <= pin_s_ff[4];
    end

  assign scl_rise = pin_s_ff[5] & ~scl_d_ff;
  assign scl_fall = ~pin_s_ff[5] & scl_d_ff;
  assign start_seen = pin_s_ff[5] & scl_d_ff & sda_d_ff & ~pin_s_ff[4];
  assign stop_seen = pin_s_ff[5] & scl_d_ff & ~sda_d_ff & pin_s_ff[4];
  assign busy = (prog_ff != 19'h0);
  assign wc_high = pin_s_ff[3];
  assign sel_match = ((shift_ff[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_MEM)
                   || (shift_ff[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_PROT))
                   && (shift_ff[`SEL_CE_MSB:`SEL_CE_LSB] == pin_s_ff[2:0]);
  assign rd_byte = prot_sel_ff ? prot_ff : mem[addr_ff];

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_in_ack = in_ack_ff;
    nxt_m_ack = m_ack_ff;
    nxt_shift = shift_ff;
    nxt_drive = drive_ff;
    nxt_addr = addr_ff;
    nxt_prot_sel = prot_sel_ff;
    nxt_prot = prot_ff;
    nxt_wrote = wrote_ff;
    nxt_prog = busy ? prog_ff - 19'h1 : prog_ff;
    mem_we = 1'b0;
    if (stop_seen)
    begin
      nxt_state = S_IDLE;
      nxt_drive = 1'b0;
      if (wrote_ff)
      begin
        nxt_prog = 19'(PROG_CYCLES);
        nxt_wrote = 1'b0;
      end
    end
    else if (start_seen && !busy)
    begin
      nxt_state = S_SEL;
      nxt_cnt = 4'h0;
      nxt_in_ack = 1'b0;
      nxt_drive = 1'b0;
    end
    else if (scl_rise && state_ff != S_IDLE && state_ff != S_WAIT)
    begin
      if (in_ack_ff)
        nxt_m_ack = ~pin_s_ff[4];
      else if (cnt_ff != `BYTE_BITS)
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (state_ff != S_RDATA)
          nxt_shift = {shift_ff[6:0], pin_s_ff[4]};
      end
    end
    else if (scl_fall)
    begin
      case (state_ff)
        S_SEL, S_ADDR, S_WDATA:
          if (in_ack_ff)
          begin
            nxt_in_ack = 1'b0;
            nxt_cnt = 4'h0;
            nxt_drive = 1'b0;
          end
          else if (cnt_ff == `BYTE_BITS)
          begin
            nxt_in_ack = 1'b1;
            nxt_drive = 1'b1;
            case (state_ff)
              S_SEL:
                if (sel_match)
                begin
                  nxt_prot_sel = (shift_ff[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_PROT);
                  nxt_state = shift_ff[`SEL_RW_BIT] ? S_RDATA : S_ADDR;
                end
                else
                begin
                  nxt_state = S_WAIT;
                  nxt_drive = 1'b0;
                end
              S_ADDR:
              begin
                nxt_addr = shift_ff;
                nxt_state = S_WDATA;
              end
              default:
                if (wc_high)
                  nxt_drive = 1'b0;
                else
                begin
                  mem_we = ~prot_sel_ff;
                  if (prot_sel_ff)
                    nxt_prot = shift_ff;
                  nxt_addr = {addr_ff[7:4], addr_ff[3:0] + 4'h1};
                  nxt_wrote = 1'b1;
                end
            endcase
          end
        S_RDATA:
          if (in_ack_ff)
          begin
            if (m_ack_ff)
            begin
              // own ack low on the select byte also reads as acked here
              nxt_shift = rd_byte;
              nxt_drive = ~rd_byte[7];
              nxt_addr = addr_ff + 8'h01;
              nxt_cnt = 4'h0;
              nxt_in_ack = 1'b0;
            end
            else
            begin
              nxt_state = S_WAIT;
              nxt_drive = 1'b0;
            end
          end
          else if (cnt_ff == `BYTE_BITS)
          begin
            nxt_drive = 1'b0;
            nxt_in_ack = 1'b1;
          end
          else
          begin
            nxt_shift = {shift_ff[6:0], 1'b1};
            nxt_drive = ~shift_ff[6];
          end
        default: nxt_drive = 1'b0;
      endcase
    end
  end

  // array kept unreset: contents survive a core reset like the real store
  always_ff @(posedge core_clk)
    if (mem_we)
      mem[addr_ff] <= shift_ff;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      in_ack_ff <= 1'b0;
      m_ack_ff <= 1'b0;
      shift_ff <= 8'h00;
      drive_ff <= 1'b0;
      addr_ff <= 8'h00;
      prot_sel_ff <= 1'b0;
      prot_ff <= `PROT_RESET;
      wrote_ff <= 1'b0;
      prog_ff <= 19'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      in_ack_ff <= nxt_in_ack;
      m_ack_ff <= nxt_m_ack;
      shift_ff <= nxt_shift;
      drive_ff <= nxt_drive;
      addr_ff <= nxt_addr;
      prot_sel_ff <= nxt_prot_sel;
      prot_ff <= nxt_prot;
      wrote_ff <= nxt_wrote;
      prog_ff <= nxt_prog;
    end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = drive_ff;
  assign prog_busy = busy;
endmodule // eeprom_slave

// file: verif/presence_detect_serial_eeprom_slave_sva.sv
// presence_detect_serial_eeprom_slave_sva: timing checks on the shared two-wire bus
// assumes one core_clk domain and wire levels already resolved by two_wire_if
`timescale 1ns/1ps
`include "two_wire_params.svh"
module presence_detect_serial_eeprom_slave_sva #(
  parameter int PROG_CYCLES = `WRC_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic prog_busy
);
  logic        sda_q_ff;
  logic        seen_start_ff;
  logic        nxt_seen_start;
  logic [7:0]  low_cnt_ff;
  logic [7:0]  nxt_low_cnt;
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // low count saturates so a parked clock cannot wrap it
  always_comb
  begin
    nxt_seen_start = seen_start_ff || (scl && sda_q_ff && !sda);
    nxt_low_cnt    = scl ? 8'h00 : low_cnt_ff + {7'h00, low_cnt_ff != 8'hff};
    nxt_busy_cnt   = prog_busy ? busy_cnt_ff + 32'h1 : 32'h0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_q_ff      <= 1'b1;
      seen_start_ff <= 1'b0;
      low_cnt_ff    <= 8'h00;
      busy_cnt_ff   <= 32'h0;
    end
    else
    begin
      sda_q_ff      <= sda;
      seen_start_ff <= nxt_seen_start;
      low_cnt_ff    <= nxt_low_cnt;
      busy_cnt_ff   <= nxt_busy_cnt;
    end
  end

  AST_DEV_EDGE_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave data drive moved while clock high");
  AST_HOST_EDGE_SCL_HIGH: assert property ($changed(host_sda_oe) && scl |-> $past(scl, 8))
    else $error("master data moved right at a clock rise");
  AST_SILENT_BEFORE_START: assert property (dev_sda_oe |-> seen_start_ff)
    else $error("slave drove before any start");
  AST_STOP_STANDBY: assert property (scl && $rose(sda) |-> !dev_sda_oe [*8])
    else $error("slave drove after stop");
  AST_DRIVE_AFTER_FALL: assert property ($changed(dev_sda_oe) |-> low_cnt_ff inside {[8'h02:8'h06]})
    else $error("slave drive change not 2 to 6 clocks after clock fall");
  AST_BUSY_SILENT: assert property (prog_busy |-> !dev_sda_oe)
    else $error("slave drove during program cycle");
  AST_BUSY_LENGTH: assert property ($fell(prog_busy) |-> (busy_cnt_ff >= PROG_CYCLES - 1)
                                    && (busy_cnt_ff <= PROG_CYCLES + 1))
    else $error("program cycle length wrong");
  AST_BUSY_ON_STOP: assert property ($rose(prog_busy) |-> scl && sda && !$past(sda, 8))
    else $error("program cycle began without a stop");

  COV_ACK: cover property ($rose(dev_sda_oe) && !host_sda_oe);
  COV_START: cover property (scl && $fell(sda));
  COV_PROG: cover property ($fell(prog_busy));
endmodule // presence_detect_serial_eeprom_slave_sva

// file: verif/presence_detect_serial_eeprom_slave_tb.sv
// presence_detect_serial_eeprom_slave_tb: master and store slave joined on one bus
// assumes pull-ups in two_wire_if; program cycle shortened to 200 clocks
`timescale 1ns/1ps
`include "two_wire_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module presence_detect_serial_eeprom_slave_tb;
  import two_wire_pkg::*;
  localparam int         PROG = 200;
  localparam logic [2:0] CE = 3'b110;
  localparam logic [7:0] SEL_W = {`TYPE_MEM, CE, 1'b0};
  localparam logic [7:0] SEL_R = {`TYPE_MEM, CE, 1'b1};
  localparam logic [7:0] SEL_PW = {`TYPE_PROT, CE, 1'b0};
  localparam logic [7:0] SEL_PR = {`TYPE_PROT, CE, 1'b1};
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_ready;
  op_e        cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic       cmd_ack = 1'b0;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       wc = 1'b0;
  logic       prog_busy;
  int         bad_count = 0;
  int         checked = 0;
  // reversed and mismatched pin codes and foreign type codes
  logic [7:0] bad_sel [4] = '{{`TYPE_MEM, 3'b011, 1'b0}, {`TYPE_MEM, 3'b100, 1'b0}, 8'h5c, 8'hbc};

  two_wire_if tw ();
  eeprom_master i_eeprom_master (.core_clk(core_clk), .rst(rst), .bus(tw.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  eeprom_slave #(.PROG_CYCLES(PROG)) i_eeprom_slave (.core_clk(core_clk), .rst(rst), .bus(tw.slave),
    .chip_enable_pin_0(1'b0), .chip_enable_pin_1(1'b1), .chip_enable_pin_2(1'b1),
    .write_control_pin(wc), .prog_busy(prog_busy));
  presence_detect_serial_eeprom_slave_sva #(.PROG_CYCLES(PROG)) i_checker (.core_clk(core_clk), .rst(rst),
    .host_scl_o(tw.host_scl_o), .host_scl_oe(tw.host_scl_oe), .host_sda_o(tw.host_sda_o),
    .host_sda_oe(tw.host_sda_oe), .dev_sda_o(tw.dev_sda_o), .dev_sda_oe(tw.dev_sda_oe),
    .scl(tw.scl), .sda(tw.sda), .prog_busy(prog_busy));

  always #10 core_clk = ~core_clk;

  // leading edge keeps two requests from landing in one time step
  task automatic op(input op_e o, input logic [7:0] d = 8'h00, input logic ak = 1'b0);
    int n;
    @(posedge core_clk);
    for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) @(posedge core_clk);
    // a run-out limit must count as a mismatch, not slip through
    `CHK("ready", 1'b1, cmd_ready)
    cmd_valid <= 1'b1;
    cmd_op    <= o;
    cmd_data  <= d;
    cmd_ack   <= ak;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    if (o inside {OP_WRITE, OP_READ})
    begin
      for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++) @(posedge core_clk);
      `CHK("rsp", 1'b1, rsp_valid)
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic nk);
    op(OP_WRITE, d);
    `CHK("nack", nk, rsp_nack)
  endtask

  task automatic rd(input logic [7:0] e, input logic ak);
    op(OP_READ, 8'h00, ak);
    `CHK("rdata", e, rsp_data)
  endtask

  task automatic setup(input logic [7:0] sel, input logic [7:0] a);
    op(OP_START);
    wr(sel, 1'b0);
    wr(a, 1'b0);
  endtask

  task automatic rand_rd(input logic [7:0] a);
    setup(SEL_W, a);
    op(OP_START);
    wr(SEL_R, 1'b0);
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 1000 && prog_busy !== lvl; n++) @(posedge core_clk);
    `CHK("busy_wait", lvl, prog_busy)
  endtask

  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // page write from 0x0e runs over the page end
    setup(SEL_W, 8'h0e);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    wr(8'h33, 1'b0);
    wr(8'h44, 1'b0);
    op(OP_STOP);
    wait_busy(1'b1);
    `CHK("busy", 1'b1, prog_busy)
    op(OP_START);
    wr(SEL_W, 1'b1);
    op(OP_STOP);
    wait_busy(1'b0);
    rand_rd(8'h0e);
    rd(8'h11, 1'b0);
    rd(8'hff, 1'b0);
    op(OP_STOP);
    op(OP_START);
    wr(SEL_R, 1'b0);
    rd(8'h22, 1'b0);
    op(OP_STOP);
    rand_rd(8'h00);
    rd(8'h33, 1'b1);
    rd(8'h44, 1'b0);
    op(OP_STOP);
    // blocked write must neither store nor start programming
    wc <= 1'b1;
    setup(SEL_W, 8'h0e);
    wr(8'h5a, 1'b1);
    op(OP_STOP);
    repeat (200) @(posedge core_clk);
    `CHK("busy", 1'b0, prog_busy)
    wc <= 1'b0;
    rand_rd(8'h0e);
    rd(8'h11, 1'b0);
    op(OP_STOP);
    op(OP_START);
    wr(SEL_PR, 1'b0);
    rd(`PROT_RESET, 1'b0);
    op(OP_STOP);
    setup(SEL_PW, 8'h00);
    wr(8'hc3, 1'b0);
    op(OP_STOP);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op(OP_START);
    wr(SEL_PR, 1'b0);
    rd(8'hc3, 1'b0);
    op(OP_STOP);
    foreach (bad_sel[i])
    begin
      op(OP_START);
      wr(bad_sel[i], 1'b1);
      op(OP_STOP);
    end
    end_sim();
  end
endmodule // presence_detect_serial_eeprom_slave_tb
